// File: include/ccps_regs.svh
// Command codes, link selects, host register offsets and timing counts
`ifndef CCPS_REGS_SVH
`define CCPS_REGS_SVH

`define CCPS_CMD_CMP_REG0 8'h10
`define CCPS_CMD_CMP_REG3 8'h13
`define CCPS_CMD_SPEED_STEP 8'h15
`define CCPS_CMD_TIMER_EXPIRY 8'h16
`define CCPS_CMD_SPLIT_PW 8'h17
`define CCPS_CMD_SPLIT_CNT 8'h18
`define CCPS_CMD_CMP_MODE 8'h20
`define CCPS_CMD_PIN_FUNC 8'h21
`define CCPS_CMD_RD_TIMER 8'h32
`define CCPS_CMD_RD_SPLIT 8'h47
`define CCPS_CMD_SPEED_UP 8'h70
`define CCPS_CMD_SPEED_DN 8'h71

`define CCPS_WSEL_CMD 2'h0
`define CCPS_WSEL_DATA_LO 2'h1
`define CCPS_WSEL_DATA_HI 2'h2
`define CCPS_WSEL_GPO 2'h3

`define CCPS_OFS_DATA_LO 5'h00
`define CCPS_OFS_DATA_HI 5'h04
`define CCPS_OFS_CMD 5'h08
`define CCPS_OFS_GPO 5'h0C
`define CCPS_OFS_RESULT 5'h10
`define CCPS_OFS_STATUS 5'h14

`define CCPS_MODE_RESET 16'h0000
`define CCPS_PIN_INPUT 2'h0
`define CCPS_PIN_GPO 2'h1
`define CCPS_PIN_STATUS 2'h2
`define CCPS_PIN_SYNC_CMP 2'h3

`define CCPS_CLK_MHZ 250
`define CCPS_GAP_NS 125
`define CCPS_GAP_CYC ((`CCPS_GAP_NS * `CCPS_CLK_MHZ + 999) / 1000)

`endif

// File: include/ccps_pkg.sv
// Types shared by both ends of the parameter command link
package ccps_pkg;
	typedef enum logic [1:0]
	{
		CCPS_OBJ_CMD_POS = 2'h0,
		CCPS_OBJ_ENC_POS = 2'h1,
		CCPS_OBJ_SPEED = 2'h2,
		CCPS_OBJ_TIMER = 2'h3
	} ccps_obj_t;
	typedef enum logic [1:0]
	{
		CCPS_COND_GE = 2'h0,
		CCPS_COND_GT = 2'h1,
		CCPS_COND_EQ = 2'h2,
		CCPS_COND_LT = 2'h3
	} ccps_cond_t;
	typedef enum logic [2:0]
	{
		CCPS_ST_IDLE = 3'h0,
		CCPS_ST_SEND_LO = 3'h1,
		CCPS_ST_SEND_HI = 3'h2,
		CCPS_ST_SEND_CMD = 3'h3,
		CCPS_ST_SEND_GPO = 3'h4,
		CCPS_ST_GAP = 3'h5
	} ccps_state_t;
endpackage

// File: include/ccps_link_if.sv
// Command link between the host processor end and the device end
`timescale 1ns/10ps
interface ccps_link_if;
	logic wr;
	logic [1:0] wsel;
	logic [15:0] wdata;
	logic busy;
	logic [31:0] rdata;
	logic [7:0] mag_status;
	logic [7:0] pin_level;
	modport host (output wr, output wsel, output wdata, input busy, input rdata,
		input mag_status, input pin_level);
	modport device (input wr, input wsel, input wdata, output busy, output rdata,
		output mag_status, output pin_level);
endinterface

// File: rtl/ccps_compare.sv
// One compare register unit: object select, condition and magnitude flags
`timescale 1ns/10ps
module ccps_compare
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [1:0] obj_sel,
	input wire logic [1:0] cond_sel,
	input wire logic [31:0] ref_val,
	input wire logic [31:0] cmd_pos,
	input wire logic [31:0] enc_pos,
	input wire logic [31:0] speed,
	input wire logic [31:0] timer,
	output logic hit,
	output logic below,
	output logic equal
);
	logic [31:0] obj_val;
	logic obj_lt;
	logic obj_eq;
	logic hit_d;

	// Object select
	assign obj_val = (obj_sel == ccps_pkg::CCPS_OBJ_CMD_POS) ? cmd_pos :
		(obj_sel == ccps_pkg::CCPS_OBJ_ENC_POS) ? enc_pos :
		(obj_sel == ccps_pkg::CCPS_OBJ_SPEED) ? speed : timer; // [RULE13]
	assign obj_lt = $signed(obj_val) < $signed(ref_val);
	assign obj_eq = obj_val == ref_val;
	// Condition select
	assign hit_d = (cond_sel == ccps_pkg::CCPS_COND_GE) ? !obj_lt :
		(cond_sel == ccps_pkg::CCPS_COND_GT) ? (!obj_lt && !obj_eq) :
		(cond_sel == ccps_pkg::CCPS_COND_EQ) ? obj_eq : obj_lt; // [RULE14]

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			hit <= 1'b0;
			below <= 1'b0;
			equal <= 1'b0;
		end
		else
		begin
			hit <= hit_d;
			below <= obj_lt; // [RULE16]
			equal <= obj_eq; // [RULE16]
		end
	end
endmodule

// File: rtl/ccps_device_end.sv
// Device end: command decode, parameter registers, compare units and pin functions
`timescale 1ns/10ps
`include "ccps_regs.svh"

// Overview of operation
// [RULE1] Speed up/down command targets speed plus step; the speed down command here targets speed minus step
// [RULE2] Command 16h loads timer expiry value
// [RULE3] Read command 32h returns present timer count
// [RULE4] Command 17h loads split period and width
// [RULE5] New split values apply without interrupting output
// [RULE6] Host always sends both split data words
// [RULE7] Read command 47h returns split period, width
// [RULE8] Command 18h loads split count, zero endless
// [RULE9] Mode commands copy low data word
// [RULE10] Reset clears all mode registers
// [RULE11] Host waits command interval before next write
// [RULE12] Command 20h sets per-register object and condition
// [RULE13] Object codes: position, encoder, speed, timer
// [RULE14] Condition codes: ge, gt, eq, lt
// [RULE15] Compare results feed output, sync, interrupt; here they drive CMP_OUT and pins 4 to 7 only, with no interrupt
// [RULE16] Magnitude relation always readable in status
// [RULE17] Software avoids speed equality at fast ramps
// [RULE18] Command 21h sets two-bit function per pin
// [RULE19] Selector 00 makes pin a readable input
// [RULE20] Selector 01 drives general output register bit
// [RULE21] Selector 10 drives fixed drive status bit
// [RULE22] Selector 11 drives sync pulses, compare results
// [RULE23] Drive status bit n maps to pin n
// [RULE24] Command completes within one clock
module ccps_device_end
(
	input wire logic CLK_SYS,
	input wire logic SYS_RST,
	ccps_link_if.device LINK,
	input wire logic [31:0] CMD_POS,
	input wire logic [31:0] ENC_POS,
	input wire logic [31:0] SPEED,
	input wire logic [31:0] TIMER_COUNT,
	input wire logic [7:0] DRV_STATUS,
	input wire logic [3:0] SYNC_PULSE,
	input wire logic [7:0] PIN_I,
	output logic [7:0] PIN_O,
	output logic [7:0] PIN_OE_N,
	output logic [3:0] CMP_OUT,
	output logic [1:0] EXT_DRIVE,
	output logic [31:0] SPEED_STEP,
	output logic [31:0] TARGET_SPEED,
	output logic SPEED_CHANGE,
	output logic [31:0] TIMER_EXPIRY,
	output logic [15:0] SPLIT_PERIOD,
	output logic [15:0] SPLIT_WIDTH,
	output logic [15:0] SPLIT_COUNT
);
	logic [15:0] data_lo_q;
	logic [15:0] data_hi_q;
	logic [31:0] cmp_reg_q [0:3];
	logic [15:0] cmp_mode_q;
	logic [15:0] pin_func_q;
	logic [7:0] gpo_q;
	logic [31:0] result_q;
	logic busy_q;
	logic [7:0] pin_o_q;
	logic [7:0] pin_oe_n_q;
	logic [31:0] data_word;
	logic [7:0] code;
	logic cmd_stb;
	logic [3:0] cmp_hit;
	logic [3:0] cmp_below;
	logic [3:0] cmp_equal;
	logic is_cmp_reg;
	logic is_speed_up;
	logic is_speed_dn;

	assign cmd_stb = LINK.wr && (LINK.wsel == `CCPS_WSEL_CMD);
	assign code = LINK.wdata[7:0];
	assign data_word = {data_hi_q, data_lo_q};
	assign is_cmp_reg = cmd_stb && (code >= `CCPS_CMD_CMP_REG0) && (code <= `CCPS_CMD_CMP_REG3);
	assign is_speed_up = cmd_stb && (code == `CCPS_CMD_SPEED_UP);
	assign is_speed_dn = cmd_stb && (code == `CCPS_CMD_SPEED_DN);

	// Data words and general output register
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
		begin
			data_lo_q <= 16'h0000;
			data_hi_q <= 16'h0000;
			gpo_q <= 8'h00;
		end
		else if (LINK.wr)
		begin
			if (LINK.wsel == `CCPS_WSEL_DATA_LO)
				data_lo_q <= LINK.wdata;
			if (LINK.wsel == `CCPS_WSEL_DATA_HI)
				data_hi_q <= LINK.wdata;
			if (LINK.wsel == `CCPS_WSEL_GPO)
				gpo_q <= LINK.wdata[7:0];
		end
	end

	// Compare registers
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
		begin
			for (int i = 0; i < 4; i++)
				cmp_reg_q[i] <= 32'h00000000;
		end
		else if (is_cmp_reg)
			cmp_reg_q[code[1:0]] <= data_word;
	end

	// Parameter setting commands, each finished in the clock it arrives
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
		begin
			SPEED_STEP <= 32'h00000000;
			TIMER_EXPIRY <= 32'h00000000;
			SPLIT_PERIOD <= 16'h0000;
			SPLIT_WIDTH <= 16'h0000;
			SPLIT_COUNT <= 16'h0000;
		end
		else if (cmd_stb)
		begin
			if (code == `CCPS_CMD_SPEED_STEP)
				SPEED_STEP <= data_word;
			if (code == `CCPS_CMD_TIMER_EXPIRY)
				TIMER_EXPIRY <= data_word; // [RULE2] [RULE24]
			if (code == `CCPS_CMD_SPLIT_PW)
			begin
				SPLIT_PERIOD <= data_lo_q; // [RULE4] [RULE5]
				SPLIT_WIDTH <= data_hi_q; // [RULE4] [RULE5]
			end
			if (code == `CCPS_CMD_SPLIT_CNT)
				SPLIT_COUNT <= data_lo_q; // [RULE8]
		end
	end

	// Write-mode registers take the low data word
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
		begin
			cmp_mode_q <= `CCPS_MODE_RESET; // [RULE10]
			pin_func_q <= `CCPS_MODE_RESET; // [RULE10]
		end
		else if (cmd_stb)
		begin
			if (code == `CCPS_CMD_CMP_MODE)
				cmp_mode_q <= data_lo_q; // [RULE9] [RULE12]
			if (code == `CCPS_CMD_PIN_FUNC)
				pin_func_q <= data_lo_q; // [RULE9] [RULE18]
		end
	end

	// Speed change target, held by the drive core as constant speed
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
		begin
			TARGET_SPEED <= 32'h00000000;
			SPEED_CHANGE <= 1'b0;
		end
		else
		begin
			SPEED_CHANGE <= is_speed_up || is_speed_dn; // [RULE1]
			if (is_speed_up)
				TARGET_SPEED <= SPEED + SPEED_STEP; // [RULE1]
			else if (is_speed_dn)
				TARGET_SPEED <= SPEED - SPEED_STEP; // [RULE1]
		end
	end

	// Read commands and command acknowledge
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
		begin
			result_q <= 32'h00000000;
			busy_q <= 1'b0;
		end
		else
		begin
			busy_q <= cmd_stb; // [RULE24]
			if (cmd_stb && (code == `CCPS_CMD_RD_TIMER))
				result_q <= TIMER_COUNT; // [RULE3]
			else if (cmd_stb && (code == `CCPS_CMD_RD_SPLIT))
				result_q <= {SPLIT_WIDTH, SPLIT_PERIOD}; // [RULE7]
		end
	end

	// Compare units
	genvar n;
	generate
		for (n = 0; n < 4; n++)
		begin : g_cmp
			ccps_compare u_cmp
			(
				.clk(CLK_SYS),
				.rst(SYS_RST),
				.obj_sel(cmp_mode_q[4 * n + 1:4 * n]), // [RULE12]
				.cond_sel(cmp_mode_q[4 * n + 3:4 * n + 2]), // [RULE12]
				.ref_val(cmp_reg_q[n]),
				.cmd_pos(CMD_POS),
				.enc_pos(ENC_POS),
				.speed(SPEED),
				.timer(TIMER_COUNT),
				.hit(cmp_hit[n]),
				.below(cmp_below[n]),
				.equal(cmp_equal[n])
			);
		end
	endgenerate

	// Pin functions
	generate
		for (n = 0; n < 8; n++)
		begin : g_pin
			logic [1:0] mode;
			logic special;
			logic src;
			if (n < 4)
			begin : g_sync
				assign special = SYNC_PULSE[n]; // [RULE22]
			end
			else
			begin : g_cmp_pin
				assign special = cmp_hit[n - 4]; // [RULE22]
			end
			assign mode = pin_func_q[2 * n + 1:2 * n];
			assign src = (mode == `CCPS_PIN_GPO) ? gpo_q[n] :
				(mode == `CCPS_PIN_STATUS) ? DRV_STATUS[n] : special; // [RULE20] [RULE21] [RULE23]
			always_ff @(posedge CLK_SYS)
			begin
				if (SYS_RST)
				begin
					pin_o_q[n] <= 1'b0;
					pin_oe_n_q[n] <= 1'b1;
				end
				else
				begin
					pin_o_q[n] <= (mode == `CCPS_PIN_INPUT) ? 1'b0 : src;
					pin_oe_n_q[n] <= mode == `CCPS_PIN_INPUT; // [RULE19]
				end
			end
		end
	endgenerate

	assign PIN_O = pin_o_q;
	assign PIN_OE_N = pin_oe_n_q;
	assign CMP_OUT = cmp_hit; // [RULE15]
	assign EXT_DRIVE = PIN_I[5:4] & pin_oe_n_q[5:4]; // [RULE19]
	assign LINK.busy = busy_q;
	assign LINK.rdata = result_q;
	assign LINK.mag_status = {cmp_equal, cmp_below}; // [RULE16]
	assign LINK.pin_level = PIN_I; // [RULE19]
endmodule

// File: rtl/ccps_host_end.sv
// Host end: Avalon-MM register slave that sequences command writes on the link
`timescale 1ns/10ps
`include "ccps_regs.svh"
module ccps_host_end
(
	input wire logic CLK_SYS,
	input wire logic SYS_RST,
	ccps_link_if.host LINK,
	input wire logic [4:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST
);
	ccps_pkg::ccps_state_t state_q;
	ccps_pkg::ccps_state_t state_d;
	logic [15:0] data_lo_q;
	logic [15:0] data_hi_q;
	logic [7:0] code_q;
	logic [7:0] gpo_q;
	logic [5:0] gap_q;
	logic rd_done_q;
	logic [31:0] read_mux;
	logic idle;
	logic wr_ok;
	logic wr_cmd;
	logic wr_gpo;

	assign idle = state_q == ccps_pkg::CCPS_ST_IDLE;
	assign wr_ok = AVS_WRITE && idle;
	assign wr_cmd = wr_ok && (AVS_ADDRESS == `CCPS_OFS_CMD);
	assign wr_gpo = wr_ok && (AVS_ADDRESS == `CCPS_OFS_GPO);
	assign AVS_WAITREQUEST = (AVS_WRITE && !idle) || (AVS_READ && !rd_done_q); // [RULE11]
	assign read_mux = (AVS_ADDRESS == `CCPS_OFS_RESULT) ? LINK.rdata :
		(AVS_ADDRESS == `CCPS_OFS_STATUS) ?
		{15'h0000, LINK.pin_level, LINK.mag_status, !idle} : 32'h00000000;

	// Every command sends both data words first
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ccps_pkg::CCPS_ST_IDLE:
			begin
				if (wr_cmd)
					state_d = ccps_pkg::CCPS_ST_SEND_LO; // [RULE6] [RULE9]
				else if (wr_gpo)
					state_d = ccps_pkg::CCPS_ST_SEND_GPO;
			end
			ccps_pkg::CCPS_ST_SEND_LO: state_d = ccps_pkg::CCPS_ST_SEND_HI;
			ccps_pkg::CCPS_ST_SEND_HI: state_d = ccps_pkg::CCPS_ST_SEND_CMD;
			ccps_pkg::CCPS_ST_SEND_CMD: state_d = ccps_pkg::CCPS_ST_GAP;
			ccps_pkg::CCPS_ST_SEND_GPO: state_d = ccps_pkg::CCPS_ST_GAP;
			ccps_pkg::CCPS_ST_GAP:
			begin
				if (gap_q == 6'h00)
					state_d = ccps_pkg::CCPS_ST_IDLE; // [RULE11]
			end
			default: state_d = ccps_pkg::CCPS_ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
		begin
			state_q <= ccps_pkg::CCPS_ST_IDLE;
			gap_q <= 6'h00;
		end
		else
		begin
			state_q <= state_d;
			if (state_d == ccps_pkg::CCPS_ST_GAP && state_q != ccps_pkg::CCPS_ST_GAP)
				gap_q <= 6'(`CCPS_GAP_CYC - 1); // [RULE11]
			else if (gap_q != 6'h00)
				gap_q <= gap_q - 6'h01;
		end
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
		begin
			data_lo_q <= 16'h0000;
			data_hi_q <= 16'h0000;
			code_q <= 8'h00;
			gpo_q <= 8'h00;
		end
		else if (wr_ok)
		begin
			if (AVS_ADDRESS == `CCPS_OFS_DATA_LO)
				data_lo_q <= AVS_WRITEDATA[15:0];
			if (AVS_ADDRESS == `CCPS_OFS_DATA_HI)
				data_hi_q <= AVS_WRITEDATA[15:0];
			if (wr_cmd)
				code_q <= AVS_WRITEDATA[7:0];
			if (wr_gpo)
				gpo_q <= AVS_WRITEDATA[7:0];
		end
	end

	// Reads answer one clock after the request
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
		begin
			rd_done_q <= 1'b0;
			AVS_READDATA <= 32'h00000000;
		end
		else
		begin
			rd_done_q <= AVS_READ && !rd_done_q;
			if (AVS_READ && !rd_done_q)
				AVS_READDATA <= read_mux;
		end
	end

	assign LINK.wr = (state_q == ccps_pkg::CCPS_ST_SEND_LO) ||
		(state_q == ccps_pkg::CCPS_ST_SEND_HI) ||
		(state_q == ccps_pkg::CCPS_ST_SEND_CMD) ||
		(state_q == ccps_pkg::CCPS_ST_SEND_GPO);
	assign LINK.wsel = (state_q == ccps_pkg::CCPS_ST_SEND_LO) ? `CCPS_WSEL_DATA_LO :
		(state_q == ccps_pkg::CCPS_ST_SEND_HI) ? `CCPS_WSEL_DATA_HI :
		(state_q == ccps_pkg::CCPS_ST_SEND_GPO) ? `CCPS_WSEL_GPO : `CCPS_WSEL_CMD;
	assign LINK.wdata = (state_q == ccps_pkg::CCPS_ST_SEND_LO) ? data_lo_q :
		(state_q == ccps_pkg::CCPS_ST_SEND_HI) ? data_hi_q :
		(state_q == ccps_pkg::CCPS_ST_SEND_GPO) ? {8'h00, gpo_q} : {8'h00, code_q};
endmodule

// File: testbench/ccps_assertions.sv
// Concurrent checks on the command link joining host end and device end
`timescale 1ns/10ps
`include "ccps_regs.svh"
module ccps_assertions
(
	input wire logic CLK_SYS,
	input wire logic SYS_RST,
	input wire logic wr,
	input wire logic [1:0] wsel,
	input wire logic [15:0] wdata,
	input wire logic busy,
	input wire logic [31:0] rdata,
	input wire logic [7:0] mag_status,
	input wire logic [7:0] pin_level
);
	logic [5:0] gap_q;
	logic [5:0] gap_d;
	wire is_cmd = wr && (wsel == `CCPS_WSEL_CMD);
	wire is_rd = is_cmd && (wdata[7:0] == `CCPS_CMD_RD_TIMER || wdata[7:0] == `CCPS_CMD_RD_SPLIT);
	assign gap_d = is_cmd ? 6'h20 : (gap_q != 6'h00 ? gap_q - 6'h01 : gap_q);
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
			gap_q <= 6'h00;
		else
			gap_q <= gap_d;
	end
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (SYS_RST);
	sequence s_lo;
		wr && wsel == `CCPS_WSEL_DATA_LO;
	endsequence
	sequence s_hi;
		wr && wsel == `CCPS_WSEL_DATA_HI;
	endsequence
	sequence s_cmd;
		is_cmd;
	endsequence
	property p_word_order;
		s_lo |=> s_hi ##1 s_cmd;
	endproperty
	a_word_order: assert property (p_word_order) else $error("link words out of order");
	property p_cmd_pair;
		s_cmd |-> $past(wr && wsel == `CCPS_WSEL_DATA_HI);
	endproperty
	a_cmd_pair: assert property (p_cmd_pair) else $error("command without high word");
	property p_busy_after_cmd;
		s_cmd |=> busy ##1 !busy;
	endproperty
	a_busy_after_cmd: assert property (p_busy_after_cmd) else $error("no busy pulse");
	property p_busy_cause;
		busy |-> $past(is_cmd);
	endproperty
	a_busy_cause: assert property (p_busy_cause) else $error("busy without command");
	property p_gap;
		wr |-> gap_q < 6'h02;
	endproperty
	a_gap: assert property (p_gap) else $error("write inside command interval");
	property p_rdata_hold;
		!($past(is_rd) || $past(is_rd, 2)) |-> $stable(rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("result moved");
	property p_reset_clear;
		$fell(SYS_RST) |-> !wr && !busy && rdata == 32'h0;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("not clear after reset");
	property p_mag_excl;
		(mag_status[3:0] & mag_status[7:4]) == 4'h0;
	endproperty
	a_mag_excl: assert property (p_mag_excl) else $error("less and equal both set");
endmodule

// File: testbench/compare_pio_param_setup_tb_top.sv
// Self-checking bench with host end and device end joined over the link
`timescale 1ns/10ps
`include "ccps_regs.svh"
module compare_pio_param_setup_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [4:0] adr = 5'h00;
	logic rd = 1'b0;
	logic wrt = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat, got, r, stp, o;
	logic wait_rq, spd_chg;
	logic [31:0] obj [4] = '{default: 32'h0};
	logic [31:0] ref_q [4];
	logic [7:0] drv = 8'h00;
	logic [3:0] syp = 4'h0;
	logic [7:0] pin_i = 8'h00;
	logic [7:0] pin_o, pin_oe_n, gpo;
	logic [3:0] cmp_out, ce, lt, eq;
	logic [1:0] ext_drv, sel;
	logic [31:0] step, tgt, tmr_exp;
	logic [15:0] sp_per, sp_wid, sp_cnt, per, wid, cnt, mode, pfun;
	int miscompares = 0;
	int n_tests = 0;
	int cyc = 0;
	int n_chg = 0;
	ccps_link_if link();
	always #2 clk = ~clk;
	ccps_host_end i_ccps_host_end (.CLK_SYS(clk), .SYS_RST(rst), .LINK(link),
		.AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wrt), .AVS_WRITEDATA(wdat),
		.AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_rq));
	ccps_device_end i_ccps_device_end (.CLK_SYS(clk), .SYS_RST(rst), .LINK(link),
		.CMD_POS(obj[0]), .ENC_POS(obj[1]), .SPEED(obj[2]), .TIMER_COUNT(obj[3]),
		.DRV_STATUS(drv), .SYNC_PULSE(syp), .PIN_I(pin_i), .PIN_O(pin_o),
		.PIN_OE_N(pin_oe_n), .CMP_OUT(cmp_out), .EXT_DRIVE(ext_drv), .SPEED_STEP(step),
		.TARGET_SPEED(tgt), .SPEED_CHANGE(spd_chg), .TIMER_EXPIRY(tmr_exp),
		.SPLIT_PERIOD(sp_per), .SPLIT_WIDTH(sp_wid), .SPLIT_COUNT(sp_cnt));
	ccps_assertions i_ccps_assertions (.CLK_SYS(clk), .SYS_RST(rst), .wr(link.wr),
		.wsel(link.wsel), .wdata(link.wdata), .busy(link.busy), .rdata(link.rdata),
		.mag_status(link.mag_status), .pin_level(link.pin_level));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Avalon cycle: request held until waitrequest is low at a rising edge
	task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
		adr <= a;
		wdat <= d;
		wrt <= w;
		rd <= !w;
		do @(posedge clk); while (wait_rq !== 1'b0);
		got = rdat;
		wrt <= 1'b0;
		rd <= 1'b0;
		@(posedge clk);
	endtask
	task automatic cmd(input logic [7:0] code, input logic [31:0] d);
		av(1'b1, `CCPS_OFS_DATA_LO, {16'h0, d[15:0]});
		av(1'b1, `CCPS_OFS_DATA_HI, {16'h0, d[31:16]});
		av(1'b1, `CCPS_OFS_CMD, {24'h0, code});
		repeat (6) @(posedge clk);
	endtask
	function automatic logic hit(input logic [31:0] a, input logic [31:0] b, input logic [1:0] c);
		case (c)
			2'h0: return $signed(a) >= $signed(b);
			2'h1: return $signed(a) > $signed(b);
			2'h2: return a == b;
			default: return $signed(a) < $signed(b);
		endcase
	endfunction
	task automatic complete_run;
		$display("Checks %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (spd_chg === 1'b1)
			n_chg <= n_chg + 1;
		if (cyc == 40000)
		begin
			miscompares++;
			complete_run();
		end
	end
	initial
	begin
		r = $urandom(32'hDA43);
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		chk("reset_regs", {sp_per, sp_wid} | sp_cnt | tmr_exp | step, 32'h0);
		chk("reset_pins", pin_oe_n, 8'hFF);
		@(posedge clk);
		av(1'b0, 5'h1C, 32'h0);
		chk("unmapped", got, 32'h0);
		for (int k = 0; k < 12; k++)
		begin
			for (int n = 0; n < 4; n++)
				obj[n] <= $urandom;
			drv <= 8'($urandom);
			syp <= 4'($urandom);
			pin_i <= 8'($urandom);
			@(posedge clk);
			r = $urandom_range(32'h7FFFFFFF, 1);
			cmd(8'h16, r);
			chk("timer_expiry", tmr_exp, r);
			cmd(8'h32, 32'h0);
			av(1'b0, `CCPS_OFS_RESULT, 32'h0);
			chk("timer_read", got, obj[3]);
			per = 16'($urandom_range(65535, 2));
			wid = 16'($urandom_range(65534, 1));
			cmd(8'h17, {wid, per});
			chk("split_pw", {sp_wid, sp_per}, {wid, per});
			cmd(8'h47, 32'h0);
			av(1'b0, `CCPS_OFS_RESULT, 32'h0);
			chk("split_read", got, {wid, per});
			cnt = k == 0 ? 16'h0 : 16'($urandom);
			cmd(8'h18, {16'($urandom), cnt});
			chk("split_count", sp_cnt, cnt);
			stp = $urandom_range(1000000, 1);
			cmd(8'h15, stp);
			chk("speed_step", step, stp);
			cmd(8'h70 + 8'(k % 2), 32'h0);
			chk("target_speed", tgt, k % 2 ? obj[2] - stp : obj[2] + stp);
			mode = 16'($urandom);
			for (int n = 0; n < 4; n++)
			begin
				ref_q[n] = obj[mode[4 * n +: 2]] + 32'($urandom_range(2, 0)) - 32'h1;
				cmd(8'h10 + 8'(n), ref_q[n]);
			end
			cmd(8'h20, {16'($urandom), mode});
			for (int n = 0; n < 4; n++)
			begin
				o = obj[mode[4 * n +: 2]];
				ce[n] = hit(o, ref_q[n], mode[4 * n + 2 +: 2]);
				lt[n] = $signed(o) < $signed(ref_q[n]);
				eq[n] = o == ref_q[n];
				chk("cmp_out", cmp_out[n], ce[n]);
			end
			av(1'b0, `CCPS_OFS_STATUS, 32'h0);
			chk("mag_status", got[8:1], {eq, lt});
			chk("pin_level", got[16:9], pin_i);
			chk("host_busy", got[0], 1'b1);
			gpo = 8'($urandom);
			pfun = 16'($urandom);
			av(1'b1, `CCPS_OFS_GPO, {24'h0, gpo});
			cmd(8'h21, {16'($urandom), pfun});
			for (int n = 0; n < 8; n++)
			begin
				sel = pfun[2 * n +: 2];
				chk("pin_oe_n", pin_oe_n[n], sel == 2'h0);
				if (sel == 2'h1)
					chk("pin_gpo", pin_o[n], gpo[n]);
				if (sel == 2'h2)
					chk("pin_status", pin_o[n], drv[n]);
				if (sel == 2'h3)
					chk("pin_sync_cmp", pin_o[n], n < 4 ? syp[n] : ce[n - 4]);
				if (sel == 2'h0 && (n == 4 || n == 5))
					chk("ext_drive", ext_drv[n - 4], pin_i[n]);
			end
		end
		chk("speed_changes", n_chg, 12);
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("rerun_regs", {sp_per, sp_wid} | sp_cnt | tmr_exp | step | tgt, 32'h0);
		chk("rerun_pins", pin_oe_n, 8'hFF);
		av(1'b0, `CCPS_OFS_RESULT, 32'h0);
		chk("rerun_result", got, 32'h0);
		complete_run();
	end
endmodule
